// ==== design/pfcfe_pkg.sv ====
// Purpose: Shared constants and types for the parallel flash host controller
// Assumes: 25 MHz core clock, byte-wide asynchronous flash bus
// Notes: Command codes besides the identifier one are our own values, shared with the bench
package pfcfe_pkg;
   localparam int CLK_PERIOD_NS = 40;
   localparam int ADDR_W = 20;
   localparam int DATA_W = 8;
   localparam int BLOCK_COUNT = 16;
   localparam int BLOCK_SHIFT = 16;
   localparam logic [19:0] TOP_BLOCK_BASE = 20'hf0000;
   localparam logic [19:0] TOP_BLOCK_LAST = 20'hfffff;
   localparam logic [19:0] MAKER_ADDR = 20'h00000;
   localparam logic [19:0] DEVICE_ADDR = 20'h00001;
   localparam logic [7:0] CMD_IDENT = 8'h90;
   // Arbitrary codes; the host passes any byte through unchanged
   localparam logic [7:0] CMD_READ_ARRAY = 8'h0f;
   localparam logic [7:0] CMD_READ_STATUS = 8'h1e;
   localparam logic [7:0] CMD_BYTE_WRITE = 8'h2d;
   localparam logic [7:0] CMD_ERASE_SETUP = 8'h3c;
   localparam logic [7:0] CMD_CONFIRM = 8'h4b;
   localparam logic [7:0] CMD_SUSPEND = 8'h69;
   localparam logic [4:0] STATUS_AFTER_WAKE = 5'h10;
   // Strobe and access widths and wake time in ns
   localparam int STROBE_NS = 80;
   localparam int ACCESS_NS = 120;
   localparam int WAKE_NS = 1000;
   localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAKE_CYC = (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 6;

   typedef struct packed {
      logic write;
      logic [19:0] addr;
      logic [7:0] data;
   } pfcfe_req_t;

   typedef struct packed {
      logic chip_sel_n;
      logic out_gate_n;
      logic write_strobe_n;
      logic powerdown_reset_n;
   } pfcfe_ctl_t;

   typedef enum logic [4:0] {
      ST_WAKE = 5'b00001,
      ST_IDLE = 5'b00010,
      ST_WR = 5'b00100,
      ST_RD = 5'b01000,
      ST_GAP = 5'b10000
   } pfcfe_state_t;
endpackage

// ==== design/pfcfe_host.sv ====
// Purpose: Host controller driving a byte-wide parallel flash over its pins
// Assumes: One request at a time; flash timing met by strobe and access counts
// Notes: Data pins split into in, out and enable; the bench resolves the wire
//
// Overview of operation
// - Data lines carry commands out, data back
// - Erase is setup then confirm command
// - Host gives address and data for write
// - Read-array command needed after write or erase
// - Identifier: address 0 maker, 1 device
`timescale 1ns/1ns
`default_nettype none
module pfcfe_host
   import pfcfe_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   input wire logic req_valid_in,
   input wire pfcfe_req_t req_in,
   input wire logic powerdown_req_in,
   output logic req_ready_out,
   output logic rsp_valid_out,
   output logic [7:0] rsp_data_out,
   output logic [3:0] rsp_block_out,
   output logic engine_busy_out,
   output pfcfe_ctl_t ctl_out,
   output logic [19:0] byte_address_out,
   output logic [7:0] data_lines_out,
   output logic data_lines_oe_out,
   input wire logic [7:0] data_lines_in,
   input wire logic automation_idle_flag_in
);
   pfcfe_state_t st_q, st_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   pfcfe_ctl_t ctl_q, ctl_d;
   logic [19:0] addr_q, addr_d;
   logic [7:0] wdat_q, wdat_d;
   logic oe_q, oe_d;
   logic rv_q, rv_d;
   logic [7:0] rdat_q, rdat_d;
   logic [3:0] blk_q, blk_d;
   logic rdy_q, rdy_d;
   // Three-stage sync for the busy flag; only stages two and three are compared
   logic [2:0] flag_sync_q, flag_sync_d;
   logic busy_q, busy_d;

   always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         flag_sync_q <= 3'h7;
      end else begin
         flag_sync_q <= flag_sync_d;
      end
   end

   always_comb begin
      flag_sync_d = {flag_sync_q[1:0], automation_idle_flag_in};
      busy_d = busy_q;
      if (flag_sync_q[1] == flag_sync_q[2]) begin
         busy_d = ~flag_sync_q[2];
      end
   end

   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      ctl_d = ctl_q;
      addr_d = addr_q;
      wdat_d = wdat_q;
      oe_d = oe_q;
      rv_d = 1'b0;
      rdat_d = rdat_q;
      blk_d = blk_q;
      rdy_d = 1'b0;
      if (powerdown_req_in) begin
         // Holding powerdown aborts any erase or write in the flash
         st_d = ST_WAKE;
         cnt_d = CNT_W'(WAKE_CYC);
         ctl_d = '{chip_sel_n: 1'b1, out_gate_n: 1'b1, write_strobe_n: 1'b1,
                   powerdown_reset_n: 1'b0};
         oe_d = 1'b0;
      end else begin
         unique case (st_q)
            ST_WAKE: begin
               ctl_d.powerdown_reset_n = 1'b1;
               // Flash ignores commands until the wake time passes
               if (cnt_q == '0) begin
                  st_d = ST_IDLE;
                  rdy_d = 1'b1;
               end else begin
                  cnt_d = cnt_q - 1'b1;
               end
            end
            ST_IDLE: begin
               rdy_d = 1'b1;
               if (req_valid_in && rdy_q) begin
                  rdy_d = 1'b0;
                  addr_d = req_in.addr;
                  wdat_d = req_in.data;
                  blk_d = req_in.addr[BLOCK_SHIFT +: 4];
                  ctl_d.chip_sel_n = 1'b0;
                  if (req_in.write) begin
                     st_d = ST_WR;
                     cnt_d = CNT_W'(STROBE_CYC);
                     ctl_d.write_strobe_n = 1'b0;
                     ctl_d.out_gate_n = 1'b1;
                     oe_d = 1'b1;
                  end else begin
                     st_d = ST_RD;
                     cnt_d = CNT_W'(ACCESS_CYC);
                     ctl_d.out_gate_n = 1'b0;
                     ctl_d.write_strobe_n = 1'b1;
                  end
               end
            end
            ST_WR: begin
               if (cnt_q == '0) begin
                  // Rising strobe latches; data held one more cycle
                  ctl_d.write_strobe_n = 1'b1;
                  st_d = ST_GAP;
                  rv_d = 1'b1;
               end else begin
                  cnt_d = cnt_q - 1'b1;
               end
            end
            ST_RD: begin
               if (cnt_q == '0) begin
                  rdat_d = data_lines_in;
                  rv_d = 1'b1;
                  ctl_d.out_gate_n = 1'b1;
                  st_d = ST_GAP;
               end else begin
                  cnt_d = cnt_q - 1'b1;
               end
            end
            ST_GAP: begin
               oe_d = 1'b0;
               ctl_d.chip_sel_n = 1'b1;
               st_d = ST_IDLE;
               rdy_d = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         // Reset holds the flash in powerdown, then waits out the wake time
         st_q <= ST_WAKE;
         cnt_q <= CNT_W'(WAKE_CYC);
         ctl_q <= 4'he;
         addr_q <= '0;
         wdat_q <= '0;
         oe_q <= 1'b0;
         rv_q <= 1'b0;
         rdat_q <= '0;
         blk_q <= '0;
         rdy_q <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         ctl_q <= ctl_d;
         addr_q <= addr_d;
         wdat_q <= wdat_d;
         oe_q <= oe_d;
         rv_q <= rv_d;
         rdat_q <= rdat_d;
         blk_q <= blk_d;
         rdy_q <= rdy_d;
         busy_q <= busy_d;
      end
   end

   assign req_ready_out = rdy_q;
   assign rsp_valid_out = rv_q;
   assign rsp_data_out = rdat_q;
   assign rsp_block_out = blk_q;
   assign engine_busy_out = busy_q;
   assign ctl_out = ctl_q;
   assign byte_address_out = addr_q;
   assign data_lines_out = wdat_q;
   assign data_lines_oe_out = oe_q;

   a_no_contention: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      !(!ctl_q.write_strobe_n && !ctl_q.out_gate_n))
      else $error("strobe and gate both active");
   a_strobe_width: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      $fell(ctl_q.write_strobe_n) |-> !ctl_q.write_strobe_n [*3])
      else $error("write strobe too short");
   a_drive_on_write: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      !ctl_q.write_strobe_n |-> oe_q && !ctl_q.chip_sel_n)
      else $error("data not driven during write");
   a_no_drive_read: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      !ctl_q.out_gate_n |-> !oe_q)
      else $error("host drives during read");
   a_pd_holds: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      powerdown_req_in |=> !ctl_q.powerdown_reset_n && ctl_q.chip_sel_n)
      else $error("powerdown not applied");
   a_wake_wait: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      $rose(ctl_q.powerdown_reset_n) |-> !rdy_q [*8])
      else $error("request accepted before wake");
   a_read_resp: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      (st_q == ST_RD && cnt_q == '0 && !powerdown_req_in) |=>
         rv_q && rdat_q == $past(data_lines_in))
      else $error("read data not returned");
   a_busy_track: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      (!automation_idle_flag_in) [*4] |=> busy_q)
      else $error("busy not reported");
endmodule
`default_nettype wire

// ==== verification/pfcfe_flash.sv ====
// Purpose: Behavioural flash device at the far side of the host
// Assumes: Program supply level fixed by SUPPLY_HIGH; pins from pfcfe_host
// Notes: Undriven data shows the inverse of the last byte
`timescale 1ns/1ns
`default_nettype none
module pfcfe_flash
   import pfcfe_pkg::*;
#(
   parameter logic [7:0] MAKER = 8'h5a, // Arbitrary value
   parameter logic [7:0] DEVICE = 8'h3c, // Arbitrary value
   parameter int BUSY_NS = 2000,
   parameter bit SUPPLY_HIGH = 1'b1
) (
   input wire pfcfe_ctl_t ctl_in,
   input wire logic [19:0] addr_in,
   input wire logic [7:0] bus_in,
   output logic [7:0] data_out,
   output logic idle_out
);
   logic [7:0] mem [0:20'hfffff];
   logic [7:0] mode = CMD_READ_ARRAY;
   logic [7:0] rd = 8'h00;
   logic busy = 1'b0;
   logic pend = 1'b0;
   logic esu = 1'b0;
   logic susp = 1'b0;
   logic drv;
   initial data_out = 8'h00;
   // Starts erased so reads never return unknowns
   initial foreach (mem[i]) mem[i] = 8'hff;
   assign drv = ctl_in.powerdown_reset_n & !ctl_in.chip_sel_n & !ctl_in.out_gate_n;
   assign idle_out = !busy;
   always @(posedge busy) begin : busy_timer
      #(BUSY_NS) busy = 1'b0;
   end
   always @(negedge ctl_in.powerdown_reset_n) begin
      disable busy_timer;
      busy = 1'b0;
      pend = 1'b0;
      esu = 1'b0;
      susp = 1'b0;
      mode = CMD_READ_ARRAY;
   end
   always @(posedge ctl_in.write_strobe_n) begin
      if (ctl_in.powerdown_reset_n && !ctl_in.chip_sel_n) begin
         if (pend) begin
            if (SUPPLY_HIGH) mem[addr_in] = bus_in;
            busy = 1'b1;
            pend = 1'b0;
            mode = CMD_READ_STATUS;
         end else if (esu && bus_in == CMD_CONFIRM) begin
            if (SUPPLY_HIGH) begin
               for (int i = 0; i < 65536; i++) mem[{addr_in[19:16], i[15:0]}] = 8'hff;
            end
            busy = 1'b1;
            mode = CMD_READ_STATUS;
         end else if (susp && bus_in == CMD_CONFIRM) begin
            susp = 1'b0;
            busy = 1'b1;
            mode = CMD_READ_STATUS;
         end else if (busy && bus_in == CMD_SUSPEND) begin
            disable busy_timer;
            busy = 1'b0;
            susp = 1'b1;
            mode = CMD_READ_STATUS;
         end else begin
            pend = bus_in == CMD_BYTE_WRITE;
            mode = bus_in;
         end
         esu = bus_in == CMD_ERASE_SETUP;
      end
   end
   always @(negedge ctl_in.out_gate_n) begin
      // Address lands in the same step as the gate; wait for it
      #1;
      case (mode)
         CMD_IDENT: rd = addr_in == MAKER_ADDR ? MAKER : (addr_in == DEVICE_ADDR ? DEVICE : 8'h00);
         CMD_READ_STATUS: rd = {!busy, 7'h00};
         default: rd = mem[addr_in];
      endcase
   end
   // Delay lets the read byte settle before it reaches the wire
   always @(drv) #2 data_out = drv ? rd : ~data_out;
endmodule
`default_nettype wire

// ==== verification/pfcfe_host_bench.sv ====
// Purpose: Self-checking bench for pfcfe_host with flash model
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Watchdog ends a hang through the same verdict task
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fails++; $display("ERROR %s exp %h got %h", n, e, g); end end
module pfcfe_host_bench
   import pfcfe_pkg::*;
;
   logic core_clk_in, sys_rst_in, req_valid_in, powerdown_req_in, req_ready_out, rsp_valid_out;
   logic engine_busy_out, data_lines_oe_out, automation_idle_flag_in;
   pfcfe_req_t req_in;
   pfcfe_ctl_t ctl_out;
   logic [7:0] rsp_data_out, data_lines_out, data_lines_in, fl_data;
   logic [3:0] rsp_block_out;
   logic [19:0] byte_address_out;
   int fails = 0;
   int checks = 0;
   assign data_lines_in = data_lines_oe_out ? data_lines_out : fl_data;
   pfcfe_host u_pfcfe_host (.core_clk_in, .sys_rst_in, .req_valid_in, .req_in, .powerdown_req_in,
      .req_ready_out, .rsp_valid_out, .rsp_data_out, .rsp_block_out, .engine_busy_out, .ctl_out,
      .byte_address_out, .data_lines_out, .data_lines_oe_out, .data_lines_in,
      .automation_idle_flag_in);
   pfcfe_flash #(.MAKER(8'h5a), .DEVICE(8'h3c), .BUSY_NS(2000)) u_pfcfe_flash (.ctl_in(ctl_out),
      .addr_in(byte_address_out), .bus_in(data_lines_in), .data_out(fl_data),
      .idle_out(automation_idle_flag_in));
   initial begin
      core_clk_in = 1'b0;
      forever #20 core_clk_in = ~core_clk_in;
   end
   always @(negedge core_clk_in) if (!sys_rst_in) `CHK("dir", 1'b1, ctl_out.write_strobe_n | ctl_out.out_gate_n)
   task automatic cyc(input int k);
      repeat (k) @(posedge core_clk_in);
      #1;
   endtask
   task automatic req(input logic w, input logic [19:0] a, input logic [7:0] d);
      int n = 0;
      while (req_ready_out !== 1'b1 && n++ < 100) cyc(1);
      if (req_ready_out !== 1'b1) fails++;
      req_valid_in = 1'b1;
      req_in = '{w, a, d};
      cyc(1);
      req_valid_in = 1'b0;
      n = 0;
      while (rsp_valid_out !== 1'b1 && n++ < 100) cyc(1);
      if (rsp_valid_out !== 1'b1) fails++;
   endtask
   task automatic wait_busy(input logic v);
      int n = 0;
      while (engine_busy_out !== v && n++ < 200) cyc(1);
      if (engine_busy_out !== v) fails++;
   endtask
   task automatic t_reset;
      sys_rst_in = 1'b1;
      cyc(4);
      `CHK("rst_ctl", 4'b1110, ctl_out)
      `CHK("rst_rdy", 1'b0, req_ready_out)
      sys_rst_in = 1'b0;
      req(0, 20'h00010, 8'h00);
      `CHK("wake_pd", 1'b1, ctl_out.powerdown_reset_n)
      `CHK("wake_arr", 8'hff, rsp_data_out)
   endtask
   task automatic t_ident;
      req(1, 20'h00000, CMD_IDENT);
      req(0, MAKER_ADDR, 8'h00);
      `CHK("maker", 8'h5a, rsp_data_out)
      req(0, DEVICE_ADDR, 8'h00);
      `CHK("device", 8'h3c, rsp_data_out)
   endtask
   task automatic t_write;
      req(1, TOP_BLOCK_LAST, CMD_BYTE_WRITE);
      req(1, TOP_BLOCK_LAST, 8'ha5);
      wait_busy(1'b1);
      `CHK("busy", 1'b1, engine_busy_out)
      wait_busy(1'b0);
      req(0, TOP_BLOCK_LAST, 8'h00);
      `CHK("status", 8'h80, rsp_data_out)
      req(1, 20'h00000, CMD_READ_ARRAY);
      req(0, TOP_BLOCK_LAST, 8'h00);
      `CHK("wr_data", 8'ha5, rsp_data_out)
      `CHK("block", 4'hf, rsp_block_out)
   endtask
   task automatic t_suspend;
      req(1, 20'he0000, CMD_ERASE_SETUP);
      req(1, 20'he0000, CMD_CONFIRM);
      wait_busy(1'b1);
      req(1, 20'he0000, CMD_SUSPEND);
      wait_busy(1'b0);
      `CHK("susp_idle", 1'b0, engine_busy_out)
      req(1, 20'h00000, CMD_READ_ARRAY);
      req(0, TOP_BLOCK_LAST, 8'h00);
      `CHK("susp_rd", 8'ha5, rsp_data_out)
      req(1, 20'he0000, CMD_CONFIRM);
      wait_busy(1'b1);
      `CHK("resume", 1'b1, engine_busy_out)
      wait_busy(1'b0);
      `CHK("erase_done", 1'b0, engine_busy_out)
   endtask
   task automatic t_abort;
      req(1, TOP_BLOCK_BASE, CMD_ERASE_SETUP);
      req(1, TOP_BLOCK_BASE, CMD_CONFIRM);
      wait_busy(1'b1);
      powerdown_req_in = 1'b1;
      cyc(6);
      `CHK("pd_pin", 1'b0, ctl_out.powerdown_reset_n)
      `CHK("pd_idle", 1'b0, engine_busy_out)
      powerdown_req_in = 1'b0;
      // Erase was aborted; whole top block reads erased in this model
      req(0, TOP_BLOCK_LAST, 8'h00);
      `CHK("wake_rd", 8'hff, rsp_data_out)
      req(1, 20'h00000, CMD_READ_STATUS);
      req(0, 20'h00000, 8'h00);
      `CHK("wake_st", {STATUS_AFTER_WAKE, 3'h0}, rsp_data_out)
   endtask
   task automatic give_verdict;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      #200000;
      fails++;
      give_verdict();
   end
   initial begin
      req_valid_in = 1'b0;
      req_in = '0;
      powerdown_req_in = 1'b0;
      t_reset();
      t_ident();
      t_write();
      t_suspend();
      t_abort();
      give_verdict();
   end
endmodule
`default_nettype wire
